/* pkg/ppr_pkg.sv */
// package: register map, field layout and reset values of the peripheral pin remap block
package ppr_pkg;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned REG_W       = 16;
  localparam int unsigned IN_SEL_W    = 7;
  localparam int unsigned OUT_SEL_W   = 6;
  localparam int unsigned IN_PIN_CNT  = 128;
  localparam int unsigned FUNC_CNT    = 64;
  localparam int unsigned OUT_PIN_CNT = 9;
  localparam int unsigned IN_LO_LSB   = 0;
  localparam int unsigned IN_HI_LSB   = 8;
  localparam int unsigned OUT_LO_LSB  = 0;
  localparam int unsigned OUT_HI_LSB  = 8;

  localparam logic [ADDR_W-1:0] OFS_UART1_RX  = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_UART2_RX  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SPI2_CD   = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_SPI2_CS   = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_PWM_SYNC  = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_DT_ONE    = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_DT_TWO3   = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_OUT_20_35 = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_OUT_36_37 = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_OUT_38_39 = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_OUT_40_41 = 12'h028;
  localparam logic [ADDR_W-1:0] OFS_OUT_RSVD4 = 12'h02C;
  localparam logic [ADDR_W-1:0] OFS_OUT_54    = 12'h030;

  localparam logic [3:0] IDX_UART1_RX  = 4'h0;
  localparam logic [3:0] IDX_UART2_RX  = 4'h1;
  localparam logic [3:0] IDX_SPI2_CD   = 4'h2;
  localparam logic [3:0] IDX_SPI2_CS   = 4'h3;
  localparam logic [3:0] IDX_PWM_SYNC  = 4'h4;
  localparam logic [3:0] IDX_DT_ONE    = 4'h5;
  localparam logic [3:0] IDX_DT_TWO3   = 4'h6;
  localparam logic [3:0] IDX_OUT_20_35 = 4'h7;
  localparam logic [3:0] IDX_OUT_36_37 = 4'h8;
  localparam logic [3:0] IDX_OUT_38_39 = 4'h9;
  localparam logic [3:0] IDX_OUT_40_41 = 4'hA;
  localparam logic [3:0] IDX_OUT_RSVD4 = 4'hB;
  localparam logic [3:0] IDX_OUT_54    = 4'hC;
  localparam logic [3:0] IDX_NONE      = 4'hF;

  localparam logic [IN_SEL_W-1:0]  IN_SEL_RST  = 7'h00;
  localparam logic [OUT_SEL_W-1:0] OUT_SEL_RST = 6'h00;
  localparam logic [OUT_SEL_W-1:0] FUNC_NONE   = 6'h00;
endpackage

/* rtl/ppr_top.sv */
// peripheral pin remap: apb registers, input selects and output function selects
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps

// Contract
// - the first uart receive input follows the pin chosen by bits 6-0 of its select register.
// - the second uart receive input follows the pin chosen by bits 6-0 of its own register.
// - the second spi clock input follows the pin chosen by bits 14-8 of the shared spi register.
// - the second spi data input follows the pin chosen by bits 6-0 of that same register.
// - the second spi client select follows bits 6-0 of its own register, upper byte unused.
// - the first pwm sync input follows bits 14-8 of its register, bits 7-0 unused.
// - the first dead-time compensation input follows bits 14-8 of its register.
// - the third dead-time compensation input follows bits 14-8 of the shared register.
// - the second dead-time compensation input follows bits 6-0 of that shared register.
// - output pin 20 is driven by the function chosen in bits 5-0 of the first output register.
// - output pins 37, 39 and 41 are driven by the functions chosen in bits 13-8 of their registers.
// - output pins 36, 38 and 40 are driven by the functions chosen in bits 5-0 of their registers.
// - output pin 54 follows bits 5-0 of its register, whose bits 13-8 stay zero.
// - every unimplemented bit reads zero and ignores writes.
module ppr_top #(
  parameter int unsigned IN_PINS = ppr_pkg::IN_PIN_CNT,
  parameter int unsigned FUNCS   = ppr_pkg::FUNC_CNT
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_b,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [ppr_pkg::ADDR_W-1:0]           paddr,
  input  wire logic [ppr_pkg::DATA_W-1:0]           pwdata,
  input  wire logic [3:0]                           pstrb,
  output logic      [ppr_pkg::DATA_W-1:0]           prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic [IN_PINS-1:0]                   pin_in,
  output logic                                      uart_one_receive,
  output logic                                      uart_two_receive,
  output logic                                      spi_two_clock_in,
  output logic                                      spi_two_data_in,
  output logic                                      spi_two_client_sel_in,
  output logic                                      pwm_sync_input_one,
  output logic                                      deadtime_comp_input_one,
  output logic                                      deadtime_comp_input_two,
  output logic                                      deadtime_comp_input_three,
  input  wire logic [FUNCS-1:0]                     periph_func_out,
  output logic      [ppr_pkg::OUT_PIN_CNT-1:0]      remap_pin_out,
  output logic      [ppr_pkg::OUT_PIN_CNT-1:0]      remap_pin_oe_b
);
  import ppr_pkg::*;

  typedef logic [IN_SEL_W-1:0]  ppr_isel_type;
  typedef logic [OUT_SEL_W-1:0] ppr_osel_type;

  typedef struct packed {
    ppr_isel_type                          uart_one_rx_pin_sel;
    ppr_isel_type                          uart_two_rx_pin_sel;
    ppr_isel_type                          spi_two_clock_pin_sel;
    ppr_isel_type                          spi_two_data_in_pin_sel;
    ppr_isel_type                          spi_two_client_sel_pin_sel;
    ppr_isel_type                          pwm_sync_in_one_pin_sel;
    ppr_isel_type                          deadtime_comp_one_pin_sel;
    ppr_isel_type                          deadtime_comp_two_pin_sel;
    ppr_isel_type                          deadtime_comp_three_pin_sel;
    ppr_osel_type [OUT_PIN_CNT-1:0]        out_func_sel;
    logic [DATA_W-1:0]                     prdata;
    logic                                  pready;
    logic                                  pslverr;
    logic [8:0]                            periph_in;
    logic [OUT_PIN_CNT-1:0]                pin_out;
    logic [OUT_PIN_CNT-1:0]                pin_oe_b;
  } ppr_state_type;

  // pins come out of reset released, every field at zero
  localparam ppr_state_type STATE_RST = '{pin_oe_b: '1, default: '0};

  ppr_state_type s_q;
  ppr_state_type s_d;
  logic [3:0]    idx;
  logic [REG_W-1:0] img;
  logic          setup;
  logic          access;

  function automatic logic [3:0] addr_index(input logic [ADDR_W-1:0] a);
    logic [3:0] r;
    r = IDX_NONE;
    unique case (a)
      OFS_UART1_RX:  r = IDX_UART1_RX;
      OFS_UART2_RX:  r = IDX_UART2_RX;
      OFS_SPI2_CD:   r = IDX_SPI2_CD;
      OFS_SPI2_CS:   r = IDX_SPI2_CS;
      OFS_PWM_SYNC:  r = IDX_PWM_SYNC;
      OFS_DT_ONE:    r = IDX_DT_ONE;
      OFS_DT_TWO3:   r = IDX_DT_TWO3;
      OFS_OUT_20_35: r = IDX_OUT_20_35;
      OFS_OUT_36_37: r = IDX_OUT_36_37;
      OFS_OUT_38_39: r = IDX_OUT_38_39;
      OFS_OUT_40_41: r = IDX_OUT_40_41;
      OFS_OUT_RSVD4: r = IDX_OUT_RSVD4;
      OFS_OUT_54:    r = IDX_OUT_54;
      default:       r = IDX_NONE;
    endcase
    return r;
  endfunction

  function automatic logic [REG_W-1:0] lo_hi_in(input ppr_isel_type hi, input ppr_isel_type lo);
    logic [REG_W-1:0] r;
    r = 16'h0000;
    r[IN_HI_LSB +: IN_SEL_W] = hi;
    r[IN_LO_LSB +: IN_SEL_W] = lo;
    return r;
  endfunction

  function automatic logic [REG_W-1:0] lo_hi_out(input ppr_osel_type hi, input ppr_osel_type lo);
    logic [REG_W-1:0] r;
    r = 16'h0000;
    r[OUT_HI_LSB +: OUT_SEL_W] = hi;
    r[OUT_LO_LSB +: OUT_SEL_W] = lo;
    return r;
  endfunction

  // unimplemented and reserved positions are built as zero here
  function automatic logic [REG_W-1:0] reg_image(input logic [3:0] i, input ppr_state_type s);
    logic [REG_W-1:0] r;
    r = 16'h0000;
    unique case (i)
      IDX_UART1_RX:  r = lo_hi_in(IN_SEL_RST, s.uart_one_rx_pin_sel);
      IDX_UART2_RX:  r = lo_hi_in(IN_SEL_RST, s.uart_two_rx_pin_sel);
      IDX_SPI2_CD:   r = lo_hi_in(s.spi_two_clock_pin_sel, s.spi_two_data_in_pin_sel);
      IDX_SPI2_CS:   r = lo_hi_in(IN_SEL_RST, s.spi_two_client_sel_pin_sel);
      IDX_PWM_SYNC:  r = lo_hi_in(s.pwm_sync_in_one_pin_sel, IN_SEL_RST);
      IDX_DT_ONE:    r = lo_hi_in(s.deadtime_comp_one_pin_sel, IN_SEL_RST);
      IDX_DT_TWO3:   r = lo_hi_in(s.deadtime_comp_three_pin_sel, s.deadtime_comp_two_pin_sel);
      IDX_OUT_20_35: r = lo_hi_out(s.out_func_sel[1], s.out_func_sel[0]);
      IDX_OUT_36_37: r = lo_hi_out(s.out_func_sel[3], s.out_func_sel[2]);
      IDX_OUT_38_39: r = lo_hi_out(s.out_func_sel[5], s.out_func_sel[4]);
      IDX_OUT_40_41: r = lo_hi_out(s.out_func_sel[7], s.out_func_sel[6]);
      IDX_OUT_54:    r = lo_hi_out(OUT_SEL_RST, s.out_func_sel[8]);
      default:       r = 16'h0000;
    endcase
    return r;
  endfunction

  function automatic logic [REG_W-1:0] merge_lanes(input logic [REG_W-1:0] old,
                                                   input logic [REG_W-1:0] wr,
                                                   input logic [1:0]       strb);
    logic [REG_W-1:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = wr[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wr[15:8];
    end
    return r;
  endfunction

  always_comb begin
    s_d    = s_q;
    setup  = psel && !penable;
    access = psel && penable && s_q.pready;
    idx    = addr_index(paddr);
    img    = merge_lanes(reg_image(idx, s_q), pwdata[REG_W-1:0], pstrb[1:0]);
    // decoding from img drops every bit that has no field behind it
    if (access && pwrite) begin
      unique case (idx)
        IDX_UART1_RX:  s_d.uart_one_rx_pin_sel        = img[IN_LO_LSB +: IN_SEL_W];
        IDX_UART2_RX:  s_d.uart_two_rx_pin_sel        = img[IN_LO_LSB +: IN_SEL_W];
        IDX_SPI2_CD: begin
          s_d.spi_two_clock_pin_sel   = img[IN_HI_LSB +: IN_SEL_W];
          s_d.spi_two_data_in_pin_sel = img[IN_LO_LSB +: IN_SEL_W];
        end
        IDX_SPI2_CS:   s_d.spi_two_client_sel_pin_sel = img[IN_LO_LSB +: IN_SEL_W];
        IDX_PWM_SYNC:  s_d.pwm_sync_in_one_pin_sel    = img[IN_HI_LSB +: IN_SEL_W];
        IDX_DT_ONE:    s_d.deadtime_comp_one_pin_sel  = img[IN_HI_LSB +: IN_SEL_W];
        IDX_DT_TWO3: begin
          s_d.deadtime_comp_three_pin_sel = img[IN_HI_LSB +: IN_SEL_W];
          s_d.deadtime_comp_two_pin_sel   = img[IN_LO_LSB +: IN_SEL_W];
        end
        IDX_OUT_20_35: begin
          s_d.out_func_sel[0] = img[OUT_LO_LSB +: OUT_SEL_W];
          s_d.out_func_sel[1] = img[OUT_HI_LSB +: OUT_SEL_W];
        end
        IDX_OUT_36_37: begin
          s_d.out_func_sel[2] = img[OUT_LO_LSB +: OUT_SEL_W];
          s_d.out_func_sel[3] = img[OUT_HI_LSB +: OUT_SEL_W];
        end
        IDX_OUT_38_39: begin
          s_d.out_func_sel[4] = img[OUT_LO_LSB +: OUT_SEL_W];
          s_d.out_func_sel[5] = img[OUT_HI_LSB +: OUT_SEL_W];
        end
        IDX_OUT_40_41: begin
          s_d.out_func_sel[6] = img[OUT_LO_LSB +: OUT_SEL_W];
          s_d.out_func_sel[7] = img[OUT_HI_LSB +: OUT_SEL_W];
        end
        IDX_OUT_54:    s_d.out_func_sel[8] = img[OUT_LO_LSB +: OUT_SEL_W];
        default: begin
        end
      endcase
    end
    // answer prepared in setup so the access phase is always one cycle
    s_d.pready  = setup;
    s_d.pslverr = setup && (idx == IDX_NONE);
    s_d.prdata  = 32'h0000_0000;
    if (setup && !pwrite) begin
      s_d.prdata = {16'h0000, reg_image(idx, s_q)};
    end
    // routing uses the stored fields, so a write steers it one edge later
    s_d.periph_in[0] = pin_in[s_q.uart_one_rx_pin_sel];
    s_d.periph_in[1] = pin_in[s_q.uart_two_rx_pin_sel];
    s_d.periph_in[2] = pin_in[s_q.spi_two_clock_pin_sel];
    s_d.periph_in[3] = pin_in[s_q.spi_two_data_in_pin_sel];
    s_d.periph_in[4] = pin_in[s_q.spi_two_client_sel_pin_sel];
    s_d.periph_in[5] = pin_in[s_q.pwm_sync_in_one_pin_sel];
    s_d.periph_in[6] = pin_in[s_q.deadtime_comp_one_pin_sel];
    s_d.periph_in[7] = pin_in[s_q.deadtime_comp_two_pin_sel];
    s_d.periph_in[8] = pin_in[s_q.deadtime_comp_three_pin_sel];
    for (int k = 0; k < OUT_PIN_CNT; k++) begin
      // function zero leaves the pin to its port logic
      s_d.pin_out[k]  = periph_func_out[s_q.out_func_sel[k]];
      s_d.pin_oe_b[k] = (s_q.out_func_sel[k] == FUNC_NONE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata                    = s_q.prdata;
  assign pready                    = s_q.pready;
  assign pslverr                   = s_q.pslverr;
  assign uart_one_receive          = s_q.periph_in[0];
  assign uart_two_receive          = s_q.periph_in[1];
  assign spi_two_clock_in          = s_q.periph_in[2];
  assign spi_two_data_in           = s_q.periph_in[3];
  assign spi_two_client_sel_in     = s_q.periph_in[4];
  assign pwm_sync_input_one        = s_q.periph_in[5];
  assign deadtime_comp_input_one   = s_q.periph_in[6];
  assign deadtime_comp_input_two   = s_q.periph_in[7];
  assign deadtime_comp_input_three = s_q.periph_in[8];
  assign remap_pin_out             = s_q.pin_out;
  assign remap_pin_oe_b            = s_q.pin_oe_b;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // lane names the byte strobe that the capture needs
  sequence s_write(logic [3:0] i, logic lane);
    access && pwrite && (idx == i) && lane;
  endsequence

  sequence s_read_setup(logic [3:0] i);
    setup && !pwrite && (idx == i);
  endsequence

  // routing follows the stored field one edge later
  a_uart_one_route: assert property ($past(rst_b) |->
    uart_one_receive == $past(pin_in[s_q.uart_one_rx_pin_sel]))
    else $error("uart one receive not routed from its selected pin");

  a_uart_one_write: assert property (s_write(IDX_UART1_RX, pstrb[0]) |=>
    s_q.uart_one_rx_pin_sel == $past(pwdata[6:0]))
    else $error("uart one select not taken from bits 6-0");

  a_uart_two_write: assert property (s_write(IDX_UART2_RX, pstrb[0]) |=>
    s_q.uart_two_rx_pin_sel == $past(pwdata[6:0]) ##1
    uart_two_receive == $past(pin_in[s_q.uart_two_rx_pin_sel]))
    else $error("uart two select or routing wrong");

  a_spi_clock_write: assert property (s_write(IDX_SPI2_CD, pstrb[1]) |=>
    s_q.spi_two_clock_pin_sel == $past(pwdata[14:8]))
    else $error("spi clock select not taken from bits 14-8");

  a_spi_data_route: assert property ($past(rst_b) |->
    spi_two_data_in == $past(pin_in[s_q.spi_two_data_in_pin_sel]))
    else $error("spi data input not routed from its selected pin");

  a_data_lane_write: assert property (s_write(IDX_SPI2_CD, pstrb[0]) |=>
    s_q.spi_two_data_in_pin_sel == $past(pwdata[6:0]))
    else $error("spi data select not taken from bits 6-0");

  // a lane left off must leave its byte alone
  a_spi_cs_keep: assert property (s_write(IDX_SPI2_CS, !pstrb[0]) |=>
    $stable(s_q.spi_two_client_sel_pin_sel))
    else $error("client select changed without its byte lane");

  a_cs_lane_write: assert property (s_write(IDX_SPI2_CS, pstrb[0]) |=>
    s_q.spi_two_client_sel_pin_sel == $past(pwdata[6:0]))
    else $error("client select not taken from bits 6-0");

  a_sync_write: assert property (s_write(IDX_PWM_SYNC, pstrb[1]) |=>
    s_q.pwm_sync_in_one_pin_sel == $past(pwdata[14:8]))
    else $error("pwm sync select not taken from bits 14-8");

  a_dt_one_write: assert property (s_write(IDX_DT_ONE, pstrb[1]) |=>
    s_q.deadtime_comp_one_pin_sel == $past(pwdata[14:8]))
    else $error("dead-time one select not taken from bits 14-8");

  a_dt_one_route: assert property ($past(rst_b) |->
    deadtime_comp_input_one == $past(pin_in[s_q.deadtime_comp_one_pin_sel]))
    else $error("dead-time one not routed from its selected pin");

  a_dt_three_route: assert property ($past(rst_b) |->
    deadtime_comp_input_three == $past(pin_in[s_q.deadtime_comp_three_pin_sel]))
    else $error("dead-time three not routed from its selected pin");

  a_dt_three_write: assert property (s_write(IDX_DT_TWO3, pstrb[1]) |=>
    s_q.deadtime_comp_three_pin_sel == $past(pwdata[14:8]))
    else $error("dead-time three select not taken from bits 14-8");

  a_dt_two_write: assert property (s_write(IDX_DT_TWO3, pstrb[0]) |=>
    s_q.deadtime_comp_two_pin_sel == $past(pwdata[6:0]))
    else $error("dead-time two select not taken from bits 6-0");

  a_pin20_write: assert property (s_write(IDX_OUT_20_35, pstrb[0]) |=>
    s_q.out_func_sel[0] == $past(pwdata[5:0]) ##1
    remap_pin_out[0] == $past(periph_func_out[s_q.out_func_sel[0]]))
    else $error("pin 20 function select or drive wrong");

  a_odd_pins_write: assert property (s_write(IDX_OUT_38_39, pstrb[1]) |=>
    s_q.out_func_sel[5] == $past(pwdata[13:8]))
    else $error("pin 39 select not taken from bits 13-8");

  a_pin37_write: assert property (s_write(IDX_OUT_36_37, pstrb[1]) |=>
    s_q.out_func_sel[3] == $past(pwdata[13:8]))
    else $error("pin 37 select not taken from bits 13-8");

  a_even_pins_drive: assert property ($past(rst_b) |->
    remap_pin_oe_b[6] == ($past(s_q.out_func_sel[6]) == FUNC_NONE))
    else $error("pin 40 enable does not follow its function select");

  a_pin36_write: assert property (s_write(IDX_OUT_36_37, pstrb[0]) |=>
    s_q.out_func_sel[2] == $past(pwdata[5:0]))
    else $error("pin 36 select not taken from bits 5-0");

  a_pin54_write: assert property (s_write(IDX_OUT_54, pstrb[0]) |=>
    s_q.out_func_sel[8] == $past(pwdata[5:0]))
    else $error("pin 54 select not taken from bits 5-0");

  a_pin54_rsvd: assert property (s_read_setup(IDX_OUT_54) |=>
    pready && prdata[15:6] == 10'h000)
    else $error("pin 54 register upper bits not zero");

  // read images: no stray ones where no field sits
  a_unimpl_zero: assert property (s_read_setup(IDX_UART1_RX) |=>
    pready && prdata[31:7] == 25'h000_0000)
    else $error("unimplemented bits of uart one register not zero");

  a_uart_two_zero: assert property (s_read_setup(IDX_UART2_RX) |=>
    pready && prdata[31:7] == 25'h000_0000)
    else $error("unimplemented bits of uart two register not zero");

  a_sync_low_zero: assert property (s_read_setup(IDX_PWM_SYNC) |=>
    pready && prdata[7:0] == 8'h00)
    else $error("pwm sync register low byte not zero");

  a_rsvd4_zero: assert property (s_read_setup(IDX_OUT_RSVD4) |=>
    prdata == 32'h0000_0000 && !pslverr)
    else $error("reserved output register not read as zero");

  a_rsvd4_keep: assert property (s_write(IDX_OUT_RSVD4, 1'b1) |=>
    $stable(s_q.out_func_sel))
    else $error("write to reserved register moved a function select");

  a_reset_clear: assert property (!$past(rst_b) |->
    s_q.uart_one_rx_pin_sel == IN_SEL_RST && s_q.out_func_sel[8] == OUT_SEL_RST
    && remap_pin_oe_b == '1)
    else $error("fields not cleared by reset");

  // no rule behind it: guards the fixed one-cycle answer
  a_apb_one_wait: assert property (setup |=> pready ##1 !pready || setup)
    else $error("apb access phase not one cycle");
endmodule

/* dv/ppr_far_model.sv */
// far-side model: remappable pin levels and peripheral output function levels
`timescale 1ns/10ps
module ppr_far_model #(
  parameter int unsigned IN_PINS = ppr_pkg::IN_PIN_CNT,
  parameter int unsigned FUNCS   = ppr_pkg::FUNC_CNT
) (
  input  wire logic [6:0]         hot_pin,
  input  wire logic [5:0]         hot_func,
  output logic      [IN_PINS-1:0] pin_in,
  output logic      [FUNCS-1:0]   periph_func_out
);
  import ppr_pkg::*;
  // one-hot levels, so a wrong select sees 0 and only the chosen line reads 1
  always_comb begin
    pin_in                    = '0;
    periph_func_out           = '0;
    pin_in[hot_pin]           = 1'b1;
    periph_func_out[hot_func] = 1'b1;
  end
endmodule

/* dv/test_peripheral_pin_remap.sv */
// testbench: apb register access and pin routing checks for the remap block
`timescale 1ns/10ps
module test_peripheral_pin_remap;
  import ppr_pkg::*;
  logic                   clk_sys;
  logic                   rst_b;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [ADDR_W-1:0]      paddr;
  logic [DATA_W-1:0]      pwdata;
  logic [3:0]             pstrb;
  logic [3:0]             strb_use;
  logic [DATA_W-1:0]      prdata;
  logic                   pready;
  logic                   pslverr;
  logic [IN_PIN_CNT-1:0]  pin_in;
  logic [FUNC_CNT-1:0]    periph_func_out;
  logic [OUT_PIN_CNT-1:0] remap_pin_out;
  logic [OUT_PIN_CNT-1:0] remap_pin_oe_b;
  logic [8:0]             route_vec;
  logic [6:0]             hot_pin;
  logic [5:0]             hot_func;
  int                     err_total;
  int                     checked;

  ppr_top u_ppr_top (
    .clk_sys                   (clk_sys),
    .rst_b                     (rst_b),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .paddr                     (paddr),
    .pwdata                    (pwdata),
    .pstrb                     (pstrb),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .pin_in                    (pin_in),
    .uart_one_receive          (route_vec[0]),
    .uart_two_receive          (route_vec[1]),
    .spi_two_clock_in          (route_vec[2]),
    .spi_two_data_in           (route_vec[3]),
    .spi_two_client_sel_in     (route_vec[4]),
    .pwm_sync_input_one        (route_vec[5]),
    .deadtime_comp_input_one   (route_vec[6]),
    .deadtime_comp_input_two   (route_vec[7]),
    .deadtime_comp_input_three (route_vec[8]),
    .periph_func_out           (periph_func_out),
    .remap_pin_out             (remap_pin_out),
    .remap_pin_oe_b            (remap_pin_oe_b)
  );

  ppr_far_model u_ppr_far_model (
    .hot_pin         (hot_pin),
    .hot_func        (hot_func),
    .pin_in          (pin_in),
    .periph_func_out (periph_func_out)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // one apb transfer; release lands at the answer edge, so callers idle one edge before the next
  task automatic apb(input logic [ADDR_W-1:0] a, input logic wr, input logic [DATA_W-1:0] wd,
                     output logic [DATA_W-1:0] rd, output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= strb_use;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (n >= 16) chk(1'b0, "no apb answer");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] rd;
    logic              e;
    apb(a, 1'b1, d, rd, e);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x, input logic xe);
    logic [DATA_W-1:0] d;
    logic              e;
    apb(a, 1'b0, 32'h0000_0000, d, e);
    chk(d === x && e === xe, $sformatf("read of %h gave %h", a, d));
  endtask

  task automatic test_reset_state();
    chk(route_vec === 9'h000 && remap_pin_oe_b === 9'h1FF, "ports after reset");
    chk(pready === 1'b0 && remap_pin_out === 9'h000, "bus after reset");
    for (int r = 0; r < 13; r++) begin
      rd_chk(ADDR_W'(4 * r), 32'h0000_0000, 1'b0);
      @(posedge clk_sys);
    end
  endtask

  task automatic test_input_routes();
    logic [ADDR_W-1:0] ofs [9];
    logic [8:0]        hi;
    logic [6:0]        p;
    ofs = '{OFS_UART1_RX, OFS_UART2_RX, OFS_SPI2_CD, OFS_SPI2_CD, OFS_SPI2_CS,
            OFS_PWM_SYNC, OFS_DT_ONE, OFS_DT_TWO3, OFS_DT_TWO3};
    hi = 9'h164;
    for (int k = 0; k < 9; k++) begin
      p = 7'(127 - 11 * k);
      hot_pin <= p;
      wr(ofs[k], hi[k] ? {17'h0_0000, p, 8'h00} : {25'h00_0000, p});
      @(posedge clk_sys);
      chk(route_vec[k] === 1'b0, "input route changed too early");
      @(posedge clk_sys);
      chk(route_vec[k] === 1'b1, "input route misses pin");
      hot_pin <= p ^ 7'h01;
      repeat (2) @(posedge clk_sys);
      chk(route_vec[k] === 1'b0, "input route on wrong pin");
    end
  endtask

  task automatic test_output_routes();
    logic [ADDR_W-1:0] a;
    logic [5:0]        f;
    for (int b = 0; b < 9; b++) begin
      f = 6'(63 - 5 * b);
      a = (b == 8) ? OFS_OUT_54 : ADDR_W'(OFS_OUT_20_35 + 4 * (b / 2));
      hot_func <= f;
      wr(a, b[0] ? {18'h0_0000, f, 8'h00} : {26'h000_0000, f});
      @(posedge clk_sys);
      chk(remap_pin_oe_b[b] === 1'b1, "pin driven too early");
      @(posedge clk_sys);
      chk(remap_pin_oe_b[b] === 1'b0 && remap_pin_out[b] === 1'b1, "pin misses func");
      hot_func <= f ^ 6'h01;
      repeat (2) @(posedge clk_sys);
      chk(remap_pin_out[b] === 1'b0, "pin on wrong func");
      wr(a, 32'h0000_0000);
      repeat (2) @(posedge clk_sys);
      chk(remap_pin_oe_b[b] === 1'b1, "pin not released");
    end
  endtask

  task automatic test_readback();
    logic [15:0] msk [13];
    msk = '{16'h007F, 16'h007F, 16'h7F7F, 16'h007F, 16'h7F00, 16'h7F00, 16'h7F7F,
            16'h3F3F, 16'h3F3F, 16'h3F3F, 16'h3F3F, 16'h0000, 16'h003F};
    for (int r = 0; r < 13; r++) begin
      wr(ADDR_W'(4 * r), 32'hFFFF_FFFF);
      @(posedge clk_sys);
      rd_chk(ADDR_W'(4 * r), {16'h0000, msk[r]}, 1'b0);
      @(posedge clk_sys);
    end
  endtask

  // a lane left off keeps its byte; follows readback, so fields hold all ones
  task automatic test_lanes();
    strb_use = 4'h2;
    wr(OFS_SPI2_CS, 32'h0000_0000);
    @(posedge clk_sys);
    rd_chk(OFS_SPI2_CS, 32'h0000_007F, 1'b0);
    @(posedge clk_sys);
    strb_use = 4'h1;
    wr(OFS_SPI2_CD, 32'h0000_0000);
    @(posedge clk_sys);
    rd_chk(OFS_SPI2_CD, 32'h0000_7F00, 1'b0);
    strb_use = 4'hF;
  endtask

  task automatic test_mid_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk(remap_pin_oe_b === 9'h1FF, "pins still driven after reset");
    rd_chk(OFS_OUT_54, 32'h0000_0000, 1'b0);
    @(posedge clk_sys);
  endtask

  // unmapped and unaligned places answer with an error and no data
  task automatic test_unmapped();
    logic [DATA_W-1:0] d;
    logic              e;
    apb(12'h034, 1'b1, 32'hFFFF_FFFF, d, e);
    chk(e === 1'b1, "unmapped write accepted");
    @(posedge clk_sys);
    rd_chk(12'h034, 32'h0000_0000, 1'b1);
    @(posedge clk_sys);
    rd_chk(12'h002, 32'h0000_0000, 1'b1);
  endtask

  initial begin
    rst_b     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = '0;
    pstrb     = 4'h0;
    strb_use  = 4'hF;
    hot_pin   = 7'h00;
    hot_func  = 6'h00;
    err_total = 0;
    checked   = 0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    test_reset_state();
    test_input_routes();
    test_output_routes();
    test_readback();
    test_lanes();
    test_mid_reset();
    test_unmapped();
    print_verdict();
  end

  // run needs well under a thousand cycles; twenty thousand means a hang
  initial begin
    #(40 * 20000);
    err_total++;
    print_verdict();
  end
endmodule
